// >>> rtl/bcce_exec.sv
`timescale 1ns/100ps
// How it works
// RULE1 - a test-skip-if-clear skips the next instruction when the chosen bit is zero.
// RULE2 - a test-skip-if-set skips the next instruction when the chosen bit is one.
// RULE3 - a taken skip discards the prefetched word and runs an idle cycle, two cycles total.
// RULE4 - clear-file-register writes zero to the register and sets the zero flag in one cycle.
// RULE5 - clear-accumulator loads zero into the accumulator and sets the zero flag in one cycle.
// RULE6 - a call first pushes the address after the call onto the stack.
// RULE7 - a call loads the 11-bit literal into the low eleven counter bits.
// RULE8 - a call fills counter bits 12 and 11 from latch bits 4 and 3.
// RULE9 - a call is one word and takes exactly two cycles.
// RULE10 - bit instructions decode a 7-bit register address and a 3-bit bit position.
// RULE11 - bit test, clear and set leave all flags unchanged.
// RULE12 - bit clear writes zero and bit set writes one to the chosen bit, keeping the others, in one cycle.
// RULE13 - bit clear and set are a whole-register read-modify-write in one cycle.
module bcce_exec
  import bcce_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 instr_valid_in,
  input  wire logic [INSTR_W-1:0]   instr_in,
  input  wire logic [PC_W-1:0]      pc_in,
  input  wire logic [DATA_W-1:0]    upper_counter_latch_in,
  input  wire logic [DATA_W-1:0]    freg_rdata_in,
  output logic      [FADDR_W-1:0]   freg_addr_out,
  output logic      [DATA_W-1:0]    freg_wdata_out,
  output logic                      freg_we_out,
  output logic                      acc_clear_out,
  output logic                      zero_flag_set_out,
  output logic                      push_out,
  output logic      [PC_W-1:0]      top_of_stack_out,
  output logic                      pc_load_out,
  output logic      [PC_W-1:0]      pc_target_out,
  output logic                      flush_out,
  output logic                      idle_op_out
);
  typedef enum logic [1:0] {BCCE_EXEC, BCCE_IDLE} bcce_state_t;

  bcce_op_t               op;
  logic [FADDR_W-1:0]     faddr;
  logic [BITSEL_W-1:0]    bitsel;
  logic [LIT_W-1:0]       lit;
  bcce_state_t            state;
  bcce_state_t            next_state;
  logic [FADDR_W-1:0]     next_freg_addr;
  logic [DATA_W-1:0]      next_freg_wdata;
  logic                   next_freg_we;
  logic                   next_acc_clear;
  logic                   next_zero_flag_set;
  logic                   next_push;
  logic [PC_W-1:0]        next_top_of_stack;
  logic                   next_pc_load;
  logic [PC_W-1:0]        next_pc_target;
  logic                   next_flush;
  logic                   next_idle_op;
  logic                   sel_bit;

  bcce_decode u_decode (
    .instr_in   (instr_in),
    .op_out     (op),
    .faddr_out  (faddr),
    .bitsel_out (bitsel),
    .lit_out    (lit)
  );

  function automatic logic [DATA_W-1:0] bit_write(input logic [DATA_W-1:0] d,
                                                  input logic [BITSEL_W-1:0] b,
                                                  input logic v);
    logic [DATA_W-1:0] r;
    r    = d;
    r[b] = v;
    return r;
  endfunction

  assign sel_bit = freg_rdata_in[bitsel];

  always_comb begin
    next_state         = BCCE_EXEC;
    next_freg_addr     = faddr;
    next_freg_wdata    = ZERO_BYTE;
    next_freg_we       = 1'b0;
    next_acc_clear     = 1'b0;
    next_zero_flag_set = 1'b0;
    next_push          = 1'b0;
    next_top_of_stack  = top_of_stack_out;
    next_pc_load       = 1'b0;
    next_pc_target     = pc_target_out;
    next_flush         = 1'b0;
    next_idle_op       = 1'b0;
    case (state)
      BCCE_IDLE: begin
        // the prefetched word is dropped here; flags untouched
        next_idle_op = 1'b1; // RULE3 RULE9
      end
      BCCE_EXEC: begin
        if (instr_valid_in) begin
          case (op)
            BCCE_OP_BCLR: begin
              next_freg_wdata = bit_write(freg_rdata_in, bitsel, 1'b0); // RULE12 RULE13
              next_freg_we    = 1'b1; // RULE11
            end
            BCCE_OP_BSET: begin
              next_freg_wdata = bit_write(freg_rdata_in, bitsel, 1'b1); // RULE12 RULE13
              next_freg_we    = 1'b1;
            end
            BCCE_OP_TSC: begin
              if (!sel_bit) begin // RULE1
                next_flush = 1'b1; // RULE3
                next_state = BCCE_IDLE;
              end
            end
            BCCE_OP_TSS: begin
              if (sel_bit) begin // RULE2
                next_flush = 1'b1; // RULE3
                next_state = BCCE_IDLE;
              end
            end
            BCCE_OP_CLEAR_FILE_REG: begin
              next_freg_wdata    = ZERO_BYTE; // RULE4
              next_freg_we       = 1'b1;
              next_zero_flag_set = 1'b1;
            end
            BCCE_OP_CLEAR_ACCUMULATOR: begin
              next_acc_clear     = 1'b1; // RULE5
              next_zero_flag_set = 1'b1;
            end
            BCCE_OP_CALL: begin
              next_push         = 1'b1; // RULE6
              next_top_of_stack = pc_in + PC_W'(1);
              next_pc_load      = 1'b1;
              next_pc_target    = {upper_counter_latch_in[LATCH_HI:LATCH_LO], lit}; // RULE7 RULE8
              next_flush        = 1'b1; // RULE9
              next_state        = BCCE_IDLE;
            end
            default: next_state = BCCE_EXEC;
          endcase
        end
      end
      default: next_state = BCCE_EXEC;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state             <= BCCE_EXEC;
      freg_addr_out     <= '0;
      freg_wdata_out    <= ZERO_BYTE;
      freg_we_out       <= 1'b0;
      acc_clear_out     <= 1'b0;
      zero_flag_set_out <= 1'b0;
      push_out          <= 1'b0;
      top_of_stack_out  <= '0;
      pc_load_out       <= 1'b0;
      pc_target_out     <= '0;
      flush_out         <= 1'b0;
      idle_op_out       <= 1'b0;
    end else begin
      state             <= next_state;
      freg_addr_out     <= next_freg_addr;
      freg_wdata_out    <= next_freg_wdata;
      freg_we_out       <= next_freg_we;
      acc_clear_out     <= next_acc_clear;
      zero_flag_set_out <= next_zero_flag_set;
      push_out          <= next_push;
      top_of_stack_out  <= next_top_of_stack;
      pc_load_out       <= next_pc_load;
      pc_target_out     <= next_pc_target;
      flush_out         <= next_flush;
      idle_op_out       <= next_idle_op;
    end
  end

  sequence s_call_issued;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_CALL;
  endsequence
  sequence s_call_done;
    push_out && pc_load_out ##1 idle_op_out;
  endsequence

  AST_SKIP_CLEAR: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSC && !sel_bit |=> flush_out ##1 idle_op_out)
    else $error("skip on clear bit not taken");
  AST_SKIP_SET: assert property (@(posedge clk_in) disable iff (srst_in) // RULE2
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSS && sel_bit |=> flush_out ##1 idle_op_out)
    else $error("skip on set bit not taken");
  AST_NO_SKIP: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSS && !sel_bit |=> !flush_out ##1 !idle_op_out)
    else $error("skip taken when bit clear");
  AST_CLEAR_FILE_REG: assert property (@(posedge clk_in) disable iff (srst_in) // RULE4
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_CLEAR_FILE_REG
    |=> freg_we_out && freg_wdata_out == ZERO_BYTE && zero_flag_set_out && freg_addr_out == $past(faddr))
    else $error("clear file register wrong");
  AST_CLEAR_ACCUMULATOR: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_CLEAR_ACCUMULATOR |=> acc_clear_out && zero_flag_set_out && !freg_we_out)
    else $error("clear accumulator wrong");
  AST_CALL_PUSH: assert property (@(posedge clk_in) disable iff (srst_in) // RULE6
    s_call_issued |=> push_out && top_of_stack_out == $past(pc_in) + PC_W'(1))
    else $error("return address wrong");
  AST_CALL_TARGET: assert property (@(posedge clk_in) disable iff (srst_in) // RULE7
    s_call_issued |=> pc_target_out[LIT_W-1:0] == $past(instr_in[LIT_W-1:0]))
    else $error("call literal wrong");
  AST_CALL_UPPER: assert property (@(posedge clk_in) disable iff (srst_in) // RULE8
    s_call_issued |=> pc_target_out[PC_W-1:LIT_W] == $past(upper_counter_latch_in[LATCH_HI:LATCH_LO]))
    else $error("call upper bits wrong");
  AST_CALL_CYCLES: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    s_call_issued |=> s_call_done ##1 !idle_op_out)
    else $error("call not two cycles");
  AST_FLAGS_KEPT: assert property (@(posedge clk_in) disable iff (srst_in) // RULE11
    state == BCCE_EXEC && instr_valid_in && (op == BCCE_OP_BCLR || op == BCCE_OP_BSET || op == BCCE_OP_TSC)
    |=> !zero_flag_set_out)
    else $error("bit op touched flags");
  AST_BIT_RMW: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_BSET
    |=> freg_we_out && freg_wdata_out == ($past(freg_rdata_in) | (8'h01 << $past(bitsel))))
    else $error("bit set data wrong");

  // shapes shared by the checks below; the first eight each name one issued instruction or a pair of them
  sequence s_skip_clr_taken;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSC && !sel_bit;
  endsequence
  sequence s_skip_set_taken;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSS && sel_bit;
  endsequence
  sequence s_skip_clr_kept;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_TSC && sel_bit;
  endsequence
  sequence s_test_issued;
    state == BCCE_EXEC && instr_valid_in && (op == BCCE_OP_TSC || op == BCCE_OP_TSS);
  endsequence
  sequence s_bit_write_issued;
    state == BCCE_EXEC && instr_valid_in && (op == BCCE_OP_BCLR || op == BCCE_OP_BSET);
  endsequence
  sequence s_bclr_issued;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_BCLR;
  endsequence
  sequence s_clear_file_reg_issued;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_CLEAR_FILE_REG;
  endsequence
  sequence s_clear_accumulator_issued;
    state == BCCE_EXEC && instr_valid_in && op == BCCE_OP_CLEAR_ACCUMULATOR;
  endsequence
  // a taken skip: discard strobe, one idle cycle, then back to work
  sequence s_skip_done;
    flush_out ##1 idle_op_out ##1 !idle_op_out;
  endsequence
  // a one-cycle instruction never opens an idle slot behind it
  sequence s_single_cycle;
    !flush_out ##1 !idle_op_out;
  endsequence
  // nothing reaches the register file, accumulator, flags or stack
  sequence s_no_pulse;
    !freg_we_out && !acc_clear_out && !zero_flag_set_out && !push_out && !pc_load_out && !flush_out;
  endsequence

  AST_NO_SKIP_CLR: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    s_skip_clr_kept |=> s_single_cycle)
    else $error("skip taken when bit set");
  AST_SKIP_CLR_CYCLES: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    s_skip_clr_taken |=> s_skip_done)
    else $error("skip on clear bit not two cycles");
  AST_SKIP_SET_CYCLES: assert property (@(posedge clk_in) disable iff (srst_in) // RULE2
    s_skip_set_taken |=> s_skip_done)
    else $error("skip on set bit not two cycles");
  AST_FLUSH_THEN_IDLE: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    flush_out |=> idle_op_out)
    else $error("discard not followed by idle cycle");
  AST_IDLE_AFTER_FLUSH: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    idle_op_out |-> $past(flush_out))
    else $error("idle cycle without discard");

  // the prefetched word is refused whatever it decodes to
  AST_IDLE_DISCARD: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    state == BCCE_IDLE |=> s_no_pulse)
    else $error("discarded word had an effect");
  AST_IDLE_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    state == BCCE_IDLE |=> state == BCCE_EXEC)
    else $error("idle cycle too long");

  AST_BIT_CLR_RMW: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    s_bclr_issued
    |=> freg_we_out && freg_wdata_out == ($past(freg_rdata_in) & ~(8'h01 << $past(bitsel))))
    else $error("bit clear data wrong");
  AST_BIT_ADDR: assert property (@(posedge clk_in) disable iff (srst_in) // RULE13
    s_bit_write_issued |=> freg_addr_out == $past(faddr) && !acc_clear_out)
    else $error("bit write address wrong");
  AST_BIT_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    s_bit_write_issued |=> s_single_cycle)
    else $error("bit write not one cycle");
  AST_TEST_QUIET: assert property (@(posedge clk_in) disable iff (srst_in) // RULE11
    s_test_issued |=> !zero_flag_set_out && !freg_we_out && !acc_clear_out)
    else $error("bit test wrote or touched flags");

  AST_CLEAR_FILE_REG_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (srst_in) // RULE4
    s_clear_file_reg_issued |=> s_single_cycle)
    else $error("clear register not one cycle");
  AST_CLEAR_ACCUMULATOR_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    s_clear_accumulator_issued |=> s_single_cycle)
    else $error("clear accumulator not one cycle");

  // stack and target words must hold through the idle slot
  AST_CALL_HOLD: assert property (@(posedge clk_in) disable iff (srst_in) // RULE6
    s_call_issued |=> ##1 $stable(top_of_stack_out) && $stable(pc_target_out))
    else $error("call address not held");
  AST_CALL_QUIET: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    s_call_issued |=> !freg_we_out && !zero_flag_set_out && !acc_clear_out)
    else $error("call touched registers or flags");
endmodule // bcce_exec

// >>> rtl/bcce_pkg.sv
package bcce_pkg;
  localparam int INSTR_W   = 14;
  localparam int PC_W      = 13;
  localparam int FADDR_W   = 7;
  localparam int BITSEL_W  = 3;
  localparam int LIT_W     = 11;
  localparam int DATA_W    = 8;
  // opcode fields
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET   = 4'h5;
  localparam logic [3:0] OPC_SKIP_CLR  = 4'h6;
  localparam logic [3:0] OPC_SKIP_SET  = 4'h7;
  localparam logic [2:0] OPC_CALL      = 3'h4;
  localparam logic [6:0] OPC_CLR_FILE  = 7'h03;
  localparam logic [13:0] OPC_CLR_ACC  = 14'h0103;
  localparam logic [13:0] IDLE_WORD    = 14'h0000;
  localparam int LATCH_LO  = 3;
  localparam int LATCH_HI  = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    BCCE_OP_NONE, BCCE_OP_BCLR, BCCE_OP_BSET, BCCE_OP_TSC, BCCE_OP_TSS,
    BCCE_OP_CLEAR_FILE_REG, BCCE_OP_CLEAR_ACCUMULATOR, BCCE_OP_CALL
  } bcce_op_t;
endpackage

// >>> rtl/bcce_decode.sv
`timescale 1ns/100ps
module bcce_decode
  import bcce_pkg::*;
(
  input  wire logic [INSTR_W-1:0]  instr_in,
  output bcce_op_t                 op_out,
  output logic     [FADDR_W-1:0]   faddr_out,
  output logic     [BITSEL_W-1:0]  bitsel_out,
  output logic     [LIT_W-1:0]     lit_out
);
  always_comb begin
    faddr_out  = instr_in[FADDR_W-1:0];                       // RULE10
    bitsel_out = instr_in[FADDR_W+BITSEL_W-1:FADDR_W];        // RULE10
    lit_out    = instr_in[LIT_W-1:0];
    op_out     = BCCE_OP_NONE;
    if (instr_in == OPC_CLR_ACC) begin
      op_out = BCCE_OP_CLEAR_ACCUMULATOR;
    end else if (instr_in[INSTR_W-1 -: $bits(OPC_CLR_FILE)] == OPC_CLR_FILE) begin
      op_out = BCCE_OP_CLEAR_FILE_REG;
    end else if (instr_in[INSTR_W-1 -: $bits(OPC_CALL)] == OPC_CALL) begin
      op_out = BCCE_OP_CALL;
    end else begin
      case (instr_in[INSTR_W-1 -: $bits(OPC_BIT_CLEAR)])
        OPC_BIT_CLEAR: op_out = BCCE_OP_BCLR;
        OPC_BIT_SET:   op_out = BCCE_OP_BSET;
        OPC_SKIP_CLR:  op_out = BCCE_OP_TSC;
        OPC_SKIP_SET:  op_out = BCCE_OP_TSS;
        default:       op_out = BCCE_OP_NONE;
      endcase
    end
  end
endmodule // bcce_decode

// >>> verif/bcce_prog_mem.sv
`timescale 1ns/100ps
module bcce_prog_mem
  import bcce_pkg::*;
(
  input  wire logic [PC_W-1:0]    addr_in,
  output logic      [INSTR_W-1:0] word_out
);
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];
  // unwritten words read as idle words so a stray fetch has no effect
  initial foreach (mem[i]) mem[i] = IDLE_WORD;
  assign word_out = mem[addr_in];
  task automatic load(input logic [PC_W-1:0] a, input logic [INSTR_W-1:0] w);
    mem[a] = w;
  endtask
endmodule // bcce_prog_mem

// >>> verif/bit_clear_call_exec_tb.sv
`timescale 1ns/100ps
module bit_clear_call_exec_tb;
  import bcce_pkg::*;
  logic                clk_in = 1'b0;
  logic                srst_in = 1'b1;
  logic                instr_valid_in = 1'b0;
  logic [PC_W-1:0]     pc_in = '0;
  logic [DATA_W-1:0]   latch = '0;
  logic [INSTR_W-1:0]  instr;
  logic [DATA_W-1:0]   regs [0:127];
  logic [DATA_W-1:0]   rdata;
  logic [FADDR_W-1:0]  freg_addr;
  logic [DATA_W-1:0]   freg_wdata;
  logic                freg_we, acc_clear, zero_set, push, pc_load, flush, idle;
  logic [PC_W-1:0]     top_of_stack, target;
  int                  num_errors = 0;
  int                  num_checks = 0;
  int                  seed = 32'h7ada995d;

  initial forever #4 clk_in = ~clk_in;
  // register file read is combinational on the word's address field
  assign rdata = regs[instr[6:0]];

  bcce_prog_mem mem_i (.addr_in(pc_in), .word_out(instr));
  bcce_exec uut (
    .clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in), .instr_in(instr),
    .pc_in(pc_in), .upper_counter_latch_in(latch), .freg_rdata_in(rdata),
    .freg_addr_out(freg_addr), .freg_wdata_out(freg_wdata), .freg_we_out(freg_we),
    .acc_clear_out(acc_clear), .zero_flag_set_out(zero_set), .push_out(push),
    .top_of_stack_out(top_of_stack), .pc_load_out(pc_load), .pc_target_out(target),
    .flush_out(flush), .idle_op_out(idle));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input int kind, input int f, input int b, input int k);
    logic [INSTR_W-1:0] w;
    logic [PC_W-1:0]    pcv;
    int rd, rn, skip, e_we, e_wd, e_z, e_acc, e_call;
    pcv = $random(seed) & 13'h1ffe;
    latch = $random(seed);
    regs[f] = $random(seed);
    rd = regs[f];
    rn = regs[f ^ 1];
    {e_we, e_wd, e_z, e_acc, e_call, skip} = '0;
    case (kind)
      0: begin w = {OPC_BIT_CLEAR, b[2:0], f[6:0]}; e_we = 1; e_wd = rd & ~(1 << b); end
      1: begin w = {OPC_BIT_SET, b[2:0], f[6:0]}; e_we = 1; e_wd = rd | (1 << b); end
      2: begin w = {OPC_SKIP_CLR, b[2:0], f[6:0]}; skip = ((rd >> b) & 1) == 0; end
      3: begin w = {OPC_SKIP_SET, b[2:0], f[6:0]}; skip = (rd >> b) & 1; end
      4: begin w = {OPC_CLR_FILE, f[6:0]}; e_we = 1; e_z = 1; end
      5: begin w = OPC_CLR_ACC; e_acc = 1; e_z = 1; end
      6: begin w = {OPC_CALL, k[10:0]}; e_call = 1; skip = 1; end
      default: w = 14'h3e00 | f[6:0];
    endcase
    mem_i.load(pcv, w);
    // the prefetched word would write if it were not discarded
    mem_i.load(pcv + 13'h1, {OPC_BIT_SET, 3'h0, f[6:0] ^ 7'h01});
    @(negedge clk_in);
    pc_in = pcv;
    instr_valid_in = 1'b1;
    @(negedge clk_in);
    pc_in = pcv + 13'h1;
    chk(freg_we, e_we, "write strobe");
    if (e_we) chk(freg_addr, f, "write address");
    if (e_we) chk(freg_wdata, e_wd, "write data");
    chk(zero_set, e_z, "zero flag");
    chk(acc_clear, e_acc, "acc clear");
    chk(push, e_call, "push");
    chk(pc_load, e_call, "pc load");
    chk(flush, skip, "flush");
    chk(idle, 0, "idle early");
    if (e_call) chk(top_of_stack, pcv + 13'h1, "return address");
    if (e_call) chk(target, {latch[4:3], k[10:0]}, "call target");
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    chk(idle, skip, "idle cycle");
    chk(freg_we, !skip, "prefetched word");
    if (!skip) chk(freg_addr, f ^ 1, "prefetched address");
    if (!skip) chk(freg_wdata, rn | 1, "prefetched data");
    chk(push | pc_load | flush, 0, "second pulse");
    @(negedge clk_in);
    chk(idle, 0, "idle end");
  endtask

  task automatic test(input int kind, input int n, input string name);
    repeat (n) run(kind, $random(seed) & 127, $random(seed) & 7, $random(seed) & 2047);
    $display("%s test done", name);
  endtask

  initial begin
    foreach (regs[i]) regs[i] = $random(seed);
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    test(0, 10, "bit clear");
    test(1, 10, "bit set");
    run(1, 127, 7, 0);
    test(2, 12, "skip if clear");
    test(3, 12, "skip if set");
    test(4, 6, "clear register");
    test(5, 3, "clear accumulator");
    test(6, 10, "call");
    run(6, 0, 0, 2047);
    test(7, 3, "unknown opcode");
    end_of_test;
  end

  // about 300 cycles of tests, so 50 us means a hang
  initial begin
    #50000;
    num_errors++;
    end_of_test;
  end
endmodule // bit_clear_call_exec_tb
